//--- rtl/bce_regs.svh
// Purpose: offsets, field positions, reset values and condition codes
// Assumes: included by the condition evaluator package users
// Notes: definitions only
`ifndef BCE_REGS_SVH
`define BCE_REGS_SVH

// register byte offsets on the apb port
`define BCE_OFF_STATUS 12'h000
`define BCE_OFF_COND_SEL 12'h004
`define BCE_OFF_COND_RESULT 12'h008

// status word bit positions
`define BCE_BIT_C 0
`define BCE_BIT_V 1
`define BCE_BIT_Z 2
`define BCE_BIT_N 3
`define BCE_BIT_UF 4
`define BCE_BIT_LV 5
`define BCE_BIT_LUF 6
`define BCE_FLAG_W 7
`define BCE_LIVE_W 5

// reset values
`define BCE_STATUS_RST 7'h00
`define BCE_COND_SEL_RST 5'h00

// condition codes
`define BCE_CC_ALWAYS 5'h00
`define BCE_CC_UNSIGNED_BELOW 5'h01
`define BCE_CC_UNSIGNED_BELOW_OR_SAME 5'h02
`define BCE_CC_UNSIGNED_ABOVE 5'h03
`define BCE_CC_UNSIGNED_ABOVE_OR_SAME 5'h04
`define BCE_CC_EQUAL 5'h05
`define BCE_CC_NOT_EQUAL 5'h06
`define BCE_CC_SIGNED_LESS 5'h07
`define BCE_CC_SIGNED_LESS_OR_EQUAL 5'h08
`define BCE_CC_SIGNED_GREATER 5'h09
`define BCE_CC_SIGNED_GREATER_OR_EQUAL 5'h0A
`define BCE_CC_UNUSED 5'h0B
`define BCE_CC_NO_OVERFLOW 5'h0C
`define BCE_CC_OVERFLOW 5'h0D
`define BCE_CC_NO_UNDERFLOW 5'h0E
`define BCE_CC_UNDERFLOW 5'h0F
`define BCE_CC_NO_STICKY_OVERFLOW 5'h10
`define BCE_CC_STICKY_OVERFLOW 5'h11
`define BCE_CC_NO_STICKY_UNDERFLOW 5'h12
`define BCE_CC_STICKY_UNDERFLOW 5'h13
`define BCE_CC_ZERO_OR_UNDERFLOW 5'h14

`endif

//--- rtl/bce_pkg.sv
// Purpose: types shared by the condition evaluator files
// Assumes: nothing
// Notes: numbers live in bce_regs.svh
package bce_pkg;
   typedef logic [4:0] cond_code_t;
   typedef logic [6:0] status_word_t;
   typedef logic [4:0] live_flags_t;
endpackage

//--- rtl/cond_eval.sv
// Purpose: combinational truth of one condition code against the flags
// Assumes: flags laid out as in the status word
// Notes: pure logic, no state
`timescale 1ns/1ns
`include "bce_regs.svh"

module cond_eval (
   // condition and flags
   input wire bce_pkg::cond_code_t i_code,
   input wire bce_pkg::status_word_t i_flags,
   // result
   output logic o_true,
   output logic o_defined
);
   import bce_pkg::*;

   ////////////////////////////////////////////////////////////////////
   // evaluation function, one arm per defined code
   function automatic logic eval_code(input cond_code_t code, input status_word_t f);
      logic c;
      logic v;
      logic z;
      logic n;
      logic uf;
      logic lv;
      logic sticky_underflow_flag;
      logic r;
      c = f[`BCE_BIT_C];
      v = f[`BCE_BIT_V];
      z = f[`BCE_BIT_Z];
      n = f[`BCE_BIT_N];
      uf = f[`BCE_BIT_UF];
      lv = f[`BCE_BIT_LV];
      sticky_underflow_flag = f[`BCE_BIT_LUF];
      // aliases share one code, so they share one arm here
      case (code)
         `BCE_CC_ALWAYS: r = 1'b1;
         `BCE_CC_UNSIGNED_BELOW: r = c;
         `BCE_CC_UNSIGNED_BELOW_OR_SAME: r = c | z;
         `BCE_CC_UNSIGNED_ABOVE: r = ~c & ~z;
         `BCE_CC_UNSIGNED_ABOVE_OR_SAME: r = ~c;
         `BCE_CC_EQUAL: r = z;
         `BCE_CC_NOT_EQUAL: r = ~z;
         `BCE_CC_SIGNED_LESS: r = n;
         `BCE_CC_SIGNED_LESS_OR_EQUAL: r = n | z;
         `BCE_CC_SIGNED_GREATER: r = ~n & ~z;
         `BCE_CC_SIGNED_GREATER_OR_EQUAL: r = ~n;
         `BCE_CC_NO_OVERFLOW: r = ~v;
         `BCE_CC_OVERFLOW: r = v;
         `BCE_CC_NO_UNDERFLOW: r = ~uf;
         `BCE_CC_UNDERFLOW: r = uf;
         `BCE_CC_NO_STICKY_OVERFLOW: r = ~lv;
         `BCE_CC_STICKY_OVERFLOW: r = lv;
         `BCE_CC_NO_STICKY_UNDERFLOW: r = ~sticky_underflow_flag;
         `BCE_CC_STICKY_UNDERFLOW: r = sticky_underflow_flag;
         `BCE_CC_ZERO_OR_UNDERFLOW: r = z | uf;
         // unused code and everything above the top code never fire
         default: r = 1'b0;
      endcase
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////
   // twenty codes are defined: all up to the top one, minus the hole
   assign o_defined = (i_code <= `BCE_CC_ZERO_OR_UNDERFLOW) &&
                      (i_code != `BCE_CC_UNUSED);
   assign o_true = eval_code(i_code, i_flags);
endmodule

//--- rtl/branch_condition_evaluator.sv
// Purpose: condition evaluator and flag store of the processor core
// Assumes: execute stage and apb master run on i_clk_sys
// Notes: results are registered, so they appear one edge after the inputs
//
// What this block does
// - code 00000 is always true, whatever the flags.
// - 00001 true on carry set; 00010 true on carry or zero.
// - 00011 true when carry and zero clear; 00100 true when carry clear.
// - 00111 true on negative set; 01000 true on negative or zero.
// - 01001 true when negative and zero clear; 01010 when negative clear.
// - zero, overflow and underflow codes test one flag set or clear.
// - codes 10000 to 10011 test the sticky overflow and underflow flags.
// - code 10100 is true on zero or floating underflow.
// - twenty codes are defined, 00000 to 10100 except 01011.
// - sticky flags follow their live flags up; clear only by reset or write.
`timescale 1ns/1ns
`include "bce_regs.svh"

module branch_condition_evaluator #(
   parameter int ADDR_W = 12
) (
   // clock and reset
   input wire logic i_clk_sys,
   input wire logic i_reset,
   // execute stage: condition query
   input wire bce_pkg::cond_code_t i_cond_code,
   // execute stage: flag update
   input wire logic i_flag_wr,
   input wire bce_pkg::live_flags_t i_flag_new,
   // apb slave
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [ADDR_W-1:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic o_pready,
   output logic [31:0] o_prdata,
   output logic o_pslverr,
   // results toward the execute stage
   output logic o_cond_true,
   output logic o_cond_defined,
   output bce_pkg::status_word_t o_status_word
);
   import bce_pkg::*;

   ////////////////////////////////////////////////////////////////////
   // elaboration check: the map needs at least 4 address bits
   if (ADDR_W < 4 || ADDR_W > 32) begin : g_bad_addr_w
      $error("ADDR_W must lie between 4 and 32");
   end

   ////////////////////////////////////////////////////////////////////
   // address decode, used for both read mux and write strobes
   function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [11:0] off);
      return a[ADDR_W-1:0] == ADDR_W'(off);
   endfunction

   status_word_t status_q;
   status_word_t status_d;
   cond_code_t cond_sel_q;
   logic pready_q;
   logic [31:0] prdata_q;
   logic pslverr_q;
   logic cond_true_q;
   logic cond_defined_q;
   logic exe_true;
   logic exe_defined;
   logic sw_true;
   logic sw_defined;

   ////////////////////////////////////////////////////////////////////
   // apb phase decode
   wire setup_ph = i_psel & ~i_penable;
   wire access_done = i_psel & i_penable & pready_q;
   wire hit_status = addr_hit(i_paddr, `BCE_OFF_STATUS);
   wire hit_sel = addr_hit(i_paddr, `BCE_OFF_COND_SEL);
   wire hit_result = addr_hit(i_paddr, `BCE_OFF_COND_RESULT);
   wire hit_any = hit_status | hit_sel | hit_result;
   wire wr_status = access_done & i_pwrite & hit_status;
   wire wr_sel = access_done & i_pwrite & hit_sel;

   ////////////////////////////////////////////////////////////////////
   // read mux; the result register is read-only, writes to it are ignored
   wire [31:0] rd_status = {25'h0000000, status_q};
   wire [31:0] rd_sel = {27'h0000000, cond_sel_q};
   wire [31:0] rd_result = {30'h00000000, sw_defined, sw_true};
   wire [31:0] rd_mux = hit_status ? rd_status :
                        hit_sel ? rd_sel :
                        hit_result ? rd_result : 32'h00000000;

   ////////////////////////////////////////////////////////////////////
   // flag store: a software write lays down a base value, then live
   // flags from the execute stage replace theirs; sticky flags take the
   // base value or'ed with their own live flag, V or UF, so a set in the
   // cycle of a clearing write still wins
   wire [6:0] base = wr_status ? i_pwdata[6:0] : status_q;
   wire [4:0] live = i_flag_wr ? i_flag_new : base[4:0];
   wire lv_next = base[`BCE_BIT_LV] | live[`BCE_BIT_V];
   wire luf_next = base[`BCE_BIT_LUF] | live[`BCE_BIT_UF];
   assign status_d = {luf_next, lv_next, live};

   ////////////////////////////////////////////////////////////////////
   // evaluators: one for the execute stage, one for software queries
   cond_eval u_exe_eval (
      .i_code(i_cond_code),
      .i_flags(status_q),
      .o_true(exe_true),
      .o_defined(exe_defined)
   );

   cond_eval u_sw_eval (
      .i_code(cond_sel_q),
      .i_flags(status_q),
      .o_true(sw_true),
      .o_defined(sw_defined)
   );

   ////////////////////////////////////////////////////////////////////
   // flag and select registers; reset clears the sticky flags too
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         status_q <= `BCE_STATUS_RST;
         cond_sel_q <= `BCE_COND_SEL_RST;
      end else begin
         status_q <= status_d;
         if (wr_sel) begin
            cond_sel_q <= i_pwdata[4:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // registered condition result; one edge of latency keeps the
   // output off the flag path at the cost of a pipeline stage
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         cond_true_q <= 1'b0;
         cond_defined_q <= 1'b0;
      end else begin
         cond_true_q <= exe_true;
         cond_defined_q <= exe_defined;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // apb answer: ready and data are prepared in the setup cycle, so
   // every access phase completes at its first edge
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         pready_q <= 1'b0;
         prdata_q <= 32'h00000000;
         pslverr_q <= 1'b0;
      end else begin
         pready_q <= setup_ph;
         if (setup_ph) begin
            prdata_q <= i_pwrite ? 32'h00000000 : rd_mux;
            pslverr_q <= ~hit_any;
         end else if (access_done) begin
            prdata_q <= 32'h00000000;
            pslverr_q <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // outputs straight from flip-flops
   assign o_pready = pready_q;
   assign o_prdata = prdata_q;
   assign o_pslverr = pslverr_q;
   assign o_cond_true = cond_true_q;
   assign o_cond_defined = cond_defined_q;
   assign o_status_word = status_q;
endmodule

//--- test/bce_checker.sv
// Purpose: concurrent checks on the condition evaluator ports
// Assumes: status word {STICKY_UNDERFLOW_FLAG,LV,UF,N,Z,V,C}, result one edge after the code
// Notes: bound to the top module below
`timescale 1ns/1ns
module bce_checker (
   // clock and reset
   input wire logic i_clk_sys,
   input wire logic i_reset,
   // inputs watched
   input wire bce_pkg::cond_code_t i_cond_code,
   input wire logic i_flag_wr,
   input wire bce_pkg::live_flags_t i_flag_new,
   input wire logic i_psel,
   input wire logic i_pwrite,
   // outputs watched
   input wire logic o_pready,
   input wire logic o_cond_true,
   input wire logic o_cond_defined,
   input wire bce_pkg::status_word_t o_status_word
);
   import bce_pkg::*;
   logic v_q;
   cond_code_t c_q;
   status_word_t s_q;
   ////////////////////////////////////////////////////////////////////////////
   // code and flags of the previous edge; v_q hides the edge straight after reset
   always_ff @(posedge i_clk_sys) begin
      v_q <= !i_reset;
      c_q <= i_cond_code;
      s_q <= o_status_word;
   end
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (i_reset);
   ////////////////////////////////////////////////////////////////////////////
   a_always_true: assert property (v_q && c_q == 5'h00 |-> o_cond_true)
      else $error("code 0 not true");
   a_unsigned_below: assert property (v_q && (c_q == 5'h01 || c_q == 5'h02)
      |-> o_cond_true == (s_q[0] | (c_q[1] & s_q[2]))) else $error("below code wrong");
   a_unsigned_above: assert property (v_q && (c_q == 5'h03 || c_q == 5'h04)
      |-> o_cond_true == (!s_q[0] & !(c_q[0] & s_q[2]))) else $error("above code wrong");
   a_signed_less: assert property (v_q && (c_q == 5'h07 || c_q == 5'h08)
      |-> o_cond_true == (s_q[3] | (c_q[3] & s_q[2]))) else $error("less code wrong");
   a_signed_greater: assert property (v_q && (c_q == 5'h09 || c_q == 5'h0A)
      |-> o_cond_true == (!s_q[3] & !(c_q[0] & s_q[2]))) else $error("greater code wrong");
   a_single_flag: assert property (v_q && c_q inside {5, 6, [12:15]} |-> o_cond_true ==
      ((c_q < 5'h0C ? s_q[2] : c_q < 5'h0E ? s_q[1] : s_q[4]) == c_q[0]))
      else $error("single flag code wrong");
   a_sticky_codes: assert property (v_q && c_q inside {[16:19]}
      |-> o_cond_true == ((c_q[1] ? s_q[6] : s_q[5]) == c_q[0])) else $error("sticky code wrong");
   a_zero_or_uf: assert property (v_q && c_q == 5'h14
      |-> o_cond_true == (s_q[2] | s_q[4])) else $error("zero or underflow wrong");
   a_undefined_false: assert property (v_q && (c_q == 5'h0B || c_q > 5'h14)
      |-> !o_cond_true && !o_cond_defined) else $error("undefined code taken");
   a_sticky_set: assert property (i_flag_wr |=> o_status_word[4:0] == $past(i_flag_new) &&
      (o_status_word[6:5] & $past({i_flag_new[4], i_flag_new[1]})) ==
      $past({i_flag_new[4], i_flag_new[1]})) else $error("flag load wrong");
   a_sticky_hold: assert property (v_q && ($fell(o_status_word[5]) || $fell(o_status_word[6]))
      |-> $past(i_psel & i_pwrite & o_pready)) else $error("sticky flag lost");
endmodule
bind branch_condition_evaluator bce_checker chk_i (.i_clk_sys(i_clk_sys), .i_reset(i_reset),
   .i_cond_code(i_cond_code), .i_flag_wr(i_flag_wr), .i_flag_new(i_flag_new),
   .i_psel(i_psel), .i_pwrite(i_pwrite), .o_pready(o_pready), .o_cond_true(o_cond_true),
   .o_cond_defined(o_cond_defined), .o_status_word(o_status_word));

//--- test/exec_stage_model.sv
// Purpose: execute stage that feeds codes and flag updates
// Assumes: one request cycle becomes one update pulse
// Notes: registered, so everything reaches the block one edge later
`timescale 1ns/1ns
module exec_stage_model (
   // requests from the bench
   input wire logic i_clk_sys,
   input wire logic i_req,
   input wire bce_pkg::cond_code_t i_code,
   input wire bce_pkg::live_flags_t i_flags,
   // toward the block
   output logic o_flag_wr = 1'b0,
   output bce_pkg::live_flags_t o_flag_new = 5'h00,
   output bce_pkg::cond_code_t o_cond_code = 5'h00
);
   // launch just after the edge, like the real pipeline register
   always @(posedge i_clk_sys) begin
      o_flag_wr <= i_req;
      o_flag_new <= i_flags;
      o_cond_code <= i_code;
   end
endmodule

//--- test/branch_condition_evaluator_bench.sv
// Purpose: every code against the status word of every write value 0 to 127, plus sticky flag behaviour
// Assumes: apb answers after one access cycle
// Notes: expectations come from the local truth table
`timescale 1ns/1ns
`include "bce_regs.svh"
module branch_condition_evaluator_bench;
   import bce_pkg::*;
   logic clk = 1'b0, rst = 1'b1, req = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
   logic rdy, err, er, ctrue, cdef, fwr;
   logic [11:0] addr = 12'h000;
   logic [31:0] wd = 32'h0, rd, rv;
   cond_code_t code = 5'h00, cc;
   live_flags_t fl = 5'h00, fn;
   status_word_t se, sw;
   int n_fail = 0, checks_done = 0, cycles = 0;
   always #5 clk = ~clk;
   exec_stage_model xm (.i_clk_sys(clk), .i_req(req), .i_code(code), .i_flags(fl),
      .o_flag_wr(fwr), .o_flag_new(fn), .o_cond_code(cc));
   branch_condition_evaluator uut (.i_clk_sys(clk), .i_reset(rst), .i_cond_code(cc),
      .i_flag_wr(fwr), .i_flag_new(fn), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
      .i_paddr(addr), .i_pwdata(wd), .o_pready(rdy), .o_prdata(rd), .o_pslverr(err),
      .o_cond_true(ctrue), .o_cond_defined(cdef), .o_status_word(sw));
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         n_fail++;
         $display("[ERR] %s expected %0h seen %0h", nm, e, g);
      end
   endtask
   // one apb transfer; request held until pready is seen high
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k = 0;
      @(posedge clk);
      psel <= 1'b1; pwr <= w; addr <= a; wd <= d;
      @(posedge clk);
      pen <= 1'b1;
      do begin @(posedge clk); k++; end while (rdy !== 1'b1 && k < 20);
      chk("pready", 1, rdy);
      rv = rd;
      er = err;
      psel <= 1'b0; pen <= 1'b0;
   endtask
   // flag update through the execute stage, then status read back
   task automatic pulse(input live_flags_t f, input status_word_t e);
      @(posedge clk); req <= 1'b1; fl <= f;
      @(posedge clk); req <= 1'b0;
      apb(0, `BCE_OFF_STATUS, 0);
      chk("status", e, rv);
      chk("status word", e, sw);
   endtask
   function automatic logic ref_t(input cond_code_t c, input status_word_t s);
      logic [20:0] t;
      t = {s[2] | s[4], s[6], !s[6], s[5], !s[5], s[4], !s[4], s[1], !s[1], 1'b0, !s[3],
         !s[3] & !s[2], s[3] | s[2], s[3], !s[2], s[2], !s[0], !s[0] & !s[2], s[0] | s[2],
         s[0], 1'b1};
      return (c <= 5'h14) ? t[c] : 1'b0;
   endfunction
   task automatic conclude;
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 80000) begin
         n_fail++;
         conclude();
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      for (int s = 0; s < 128; s++) begin
         // a written overflow or underflow also raises its sticky copy
         se = status_word_t'(s) | {s[4], s[1], 5'h00};
         apb(1, `BCE_OFF_STATUS, 32'(s));
         apb(0, `BCE_OFF_STATUS, 0);
         chk("status wr", se, rv);
         for (int c = 0; c < 32; c++) begin
            @(posedge clk); code <= 5'(c);
            repeat (3) @(posedge clk);
            chk("cond", ref_t(5'(c), se), ctrue);
            chk("defined", (c != 11 && c <= 20), cdef);
            apb(1, `BCE_OFF_COND_SEL, 32'(c));
            apb(0, `BCE_OFF_COND_RESULT, 0);
            chk("result", {(c != 11 && c <= 20), ref_t(5'(c), se)}, rv);
         end
      end
      apb(1, `BCE_OFF_STATUS, 0);
      pulse(5'h02, 7'h22);
      pulse(5'h00, 7'h20);
      pulse(5'h10, 7'h70);
      pulse(5'h00, 7'h60);
      apb(1, `BCE_OFF_STATUS, 0);
      apb(0, `BCE_OFF_STATUS, 0);
      chk("status clr", 0, rv);
      apb(0, 12'h010, 0);
      chk("slverr", 1, er);
      conclude();
   end
endmodule
